// >>> dv/pcd_link_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pcd_link_monitor
   import pcd_pkg::*;
(
   input wire logic                    ref_clk,
   input wire logic                    srst,
   input wire logic                    pulse_line,
   input wire logic                    sign_line,
   input wire logic                    out_cmd,
   input wire logic                    out_opto_on,
   input wire logic                    step_pulse,
   input wire logic                    step_fwd,
   input wire logic                    bad_edge,
   input wire logic signed [CNT_W-1:0] position
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   chk_step_cause: assert property (step_pulse |-> $past(pulse_line,3) && !$past(pulse_line,5))
      else $error("step without pulse rise");
   chk_dir_sense: assert property (step_pulse |-> step_fwd == !$past(sign_line,3))
      else $error("step direction wrong");
   chk_pos_step: assert property (step_pulse |-> position == $past(position) + (step_fwd ? 1 : -1))
      else $error("position step wrong");
   chk_pos_hold: assert property (!step_pulse |-> $stable(position))
      else $error("position moved without step");
   chk_pulse_single: assert property (step_pulse |=> !step_pulse)
      else $error("step pulse too long");
   chk_bad_quiet: assert property (!bad_edge)
      else $error("bad edge outside quadrature");
   chk_opto_follow: assert property (out_opto_on == $past(out_cmd))
      else $error("output state mismatch");
   chk_line_width: assert property ($rose(pulse_line) |=> pulse_line[*2])
      else $error("pulse high too short");
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,s) begin cmp_count++; if ((s)!==(e)) begin num_errors++; $display("ERROR %s exp %0d got %0d",n,e,s); end end
module tb;
   import pcd_pkg::*;
   logic ref_clk = 0, srst = 1, step_req = 0, step_dir = 0, out_cmd = 0;
   logic step_busy, out_opto_on, step_pulse, step_fwd, bad_edge;
   logic signed [CNT_W-1:0] position;
   int num_errors = 0, cmp_count = 0, expv = 0, exp_fr = 0, exp_q = 0;
   pcd_link_if lnk();
   pcd_ctrl_end #(.HALF_CYC(2)) pcd_ctrl_end_inst (.ref_clk(ref_clk), .srst(srst), .link(lnk),
      .form(FORM_PULSE_DIR), .step_req(step_req), .step_dir(step_dir), .step_busy(step_busy));
   pcd_dev_end pcd_dev_end_inst (.ref_clk(ref_clk), .srst(srst), .link(lnk), .out_cmd(out_cmd),
      .out_opto_on(out_opto_on), .step_pulse(step_pulse), .step_fwd(step_fwd),
      .bad_edge(bad_edge), .position(position));
   pcd_link_monitor pcd_link_monitor_inst (.ref_clk(ref_clk), .srst(srst),
      .pulse_line(lnk.pulse_line), .sign_line(lnk.sign_line), .out_cmd(out_cmd),
      .out_opto_on(out_opto_on), .step_pulse(step_pulse), .step_fwd(step_fwd),
      .bad_edge(bad_edge), .position(position));
   // pair 0 runs separate trains, pair 1 inverted quadrature
   for (genvar k = 0; k < 2; k++) begin : gen_alt
      pcd_link_if lnk_alt();
      logic signed [CNT_W-1:0] pos;
      pcd_ctrl_end #(.HALF_CYC(2)) pcd_ctrl_end_inst (.ref_clk(ref_clk), .srst(srst),
         .link(lnk_alt), .form(k == 1 ? FORM_QUAD : FORM_FWD_REV), .step_req(step_req),
         .step_dir(step_dir), .step_busy());
      pcd_dev_end #(.FORM(k == 1 ? FORM_QUAD : FORM_FWD_REV), .INVERT(k == 1))
         pcd_dev_end_inst (.ref_clk(ref_clk), .srst(srst), .link(lnk_alt), .out_cmd(1'b0),
         .out_opto_on(), .step_pulse(), .step_fwd(), .bad_edge(), .position(pos));
   end
   always #20 ref_clk = ~ref_clk;
   task automatic end_of_test();
      if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // one step, then wait past the three-cycle decode latency
   task automatic step(input logic d);
      int i;
      @(posedge ref_clk) begin step_req <= 1; step_dir <= d; end
      for (i = 0; i < 20 && step_busy !== 1'b1; i++) @(posedge ref_clk);
      step_req <= 0;
      for (i = 0; i < 40 && step_busy !== 1'b0; i++) @(posedge ref_clk);
      repeat (6) @(posedge ref_clk);
      expv += d ? -1 : 1;
      exp_fr += d ? -1 : 1;
      exp_q += d ? 1 : -1;
      `CHK("position", expv, position)
      `CHK("pos_fwd_rev", exp_fr, gen_alt[0].pos)
      `CHK("pos_quad_inv", exp_q, gen_alt[1].pos)
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      srst <= 0;
      repeat (3) step(1'b0);
      repeat (2) step(1'b1);
      step(1'b0);
      `CHK("opto_off", 1'b0, out_opto_on)
      out_cmd <= 1;
      repeat (2) @(posedge ref_clk);
      `CHK("opto_on", 1'b1, out_opto_on)
      end_of_test();
   end
   initial begin
      #50us;
      num_errors++;
      end_of_test();
   end
endmodule
`default_nettype wire

// >>> inc/pcd_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pcd_link_if;
   logic pulse_line;
   logic sign_line;
   modport device (input pulse_line, input sign_line);
   modport ctrl   (output pulse_line, output sign_line);
endinterface
`default_nettype wire

// >>> inc/pcd_pkg.sv
package pcd_pkg;
   // command forms
   localparam logic [1:0] FORM_PULSE_DIR  = 2'h0;
   localparam logic [1:0] FORM_FWD_REV    = 2'h1;
   localparam logic [1:0] FORM_QUAD       = 2'h2;
   localparam int         CLK_HZ          = 25000000;
   // rate limits in hertz
   localparam int         PULSE_MAX_HZ    = 500000;
   localparam int         QUAD_MAX_HZ     = 300000;
   localparam int         OC_MAX_HZ       = 200000;
   // shortest half period, or quarter period for quadrature, at the limit, in cycles, rounded down
   localparam int         PULSE_HALF_CYC  = CLK_HZ / (2 * PULSE_MAX_HZ);
   localparam int         QUAD_QTR_CYC    = CLK_HZ / (4 * QUAD_MAX_HZ);
   localparam int         OC_HALF_CYC     = CLK_HZ / (2 * OC_MAX_HZ);
   localparam int         CNT_W           = 32;
endpackage

// >>> src/pcd_ctrl_end.sv
`timescale 1ns/10ps
`default_nettype none
// issues one step per request; half period set by a divider so rates stay legal
module pcd_ctrl_end
   import pcd_pkg::*;
#(
   parameter int HALF_CYC = OC_HALF_CYC
) (
   input  wire logic       ref_clk,
   input  wire logic       srst,
   pcd_link_if.ctrl        link,
   input  wire logic [1:0] form,
   input  wire logic       step_req,
   input  wire logic       step_dir,
   output logic            step_busy
);
   import pcd_pkg::*;
   localparam int HW = $clog2(HALF_CYC + 1);
   logic [HW-1:0] tmr_reg;
   logic [1:0]    ph_reg;
   logic          a_reg;
   logic          b_reg;
   logic [1:0]    left_reg;
   logic          dir_reg;
   assign link.pulse_line = a_reg;
   assign link.sign_line  = b_reg;
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         tmr_reg   <= '0;
         a_reg     <= 1'b0;
         b_reg     <= 1'b0;
         ph_reg    <= 2'h0;
         left_reg  <= 2'h0;
         dir_reg   <= 1'b0;
         step_busy <= 1'b0;
      end else if (tmr_reg != '0) begin
         tmr_reg <= tmr_reg - 1'b1;  // RL3 RL4 RL5 RL7
      end else if (left_reg != 2'h0) begin
         tmr_reg  <= HW'(HALF_CYC);
         left_reg <= left_reg - 2'h1;
         unique case (form)
            FORM_PULSE_DIR: a_reg <= ~a_reg;
            FORM_FWD_REV: begin
               if (dir_reg) b_reg <= ~b_reg;
               else a_reg <= ~a_reg;
            end
            default: begin
               // one gray step per quarter cycle
               ph_reg <= dir_reg ? ph_reg - 2'h1 : ph_reg + 2'h1;  // RL6
               a_reg  <= (dir_reg ? ph_reg - 2'h1 : ph_reg + 2'h1) inside {2'h1, 2'h2};
               b_reg  <= (dir_reg ? ph_reg - 2'h1 : ph_reg + 2'h1) inside {2'h2, 2'h3};
            end
         endcase
         if (left_reg == 2'h1) step_busy <= 1'b0;
      end else if (step_req) begin
         step_busy <= 1'b1;
         dir_reg   <= step_dir;
         tmr_reg   <= HW'(HALF_CYC);
         if (form == FORM_PULSE_DIR) begin
            b_reg    <= step_dir;
            left_reg <= 2'h2;
         end else begin
            left_reg <= (form == FORM_QUAD) ? 2'h1 : 2'h2;
         end
      end
   end
endmodule
`default_nettype wire

// >>> src/pcd_dev_end.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [RL1] form 0 pulse-dir, 1 fwd/rev, 2 quadrature
// [RL2] invert swaps forward and reverse
// [RL3] pulse-dir counts up to 500 kHz
// [RL4] fwd/rev trains count up to 500 kHz
// [RL5] quadrature decodes up to 300 kHz
// [RL6] differential controller may reach 500 kHz
// [RL7] open-collector controller limited to 200 kHz
// [RL8] rs485/can pair chosen by jumper
// [RL9] output active only while optocoupler conducts
// [RL10] quadrature direction from leading phase, skip illegal
module pcd_dev_end
   import pcd_pkg::*;
#(
   parameter logic [1:0] FORM   = FORM_PULSE_DIR,
   parameter logic       INVERT = 1'b0
) (
   input  wire logic             ref_clk,
   input  wire logic             srst,
   pcd_link_if.device            link,
   input  wire logic             out_cmd,
   output logic                  out_opto_on,
   output logic                  step_pulse,
   output logic                  step_fwd,
   output logic                  bad_edge,
   output logic signed [CNT_W-1:0] position
);
   import pcd_pkg::*;

   // number of command lines sampled from the link: pulse is bit 0, sign bit 1
   localparam int LINES = 2;

   // one-hot picture of the line pair; an illegal jump shows as the opposite code
   typedef enum logic [3:0] {
      PH_LL = 4'h1,
      PH_HL = 4'h2,
      PH_HH = 4'h4,
      PH_LH = 4'h8
   } pcd_phase_type;

   logic        [LINES-1:0] line_pin;
   logic        [LINES-1:0] s1_reg;
   logic        [LINES-1:0] s2_reg;
   logic        [LINES-1:0] prev_reg;
   pcd_phase_type           ph_now;
   pcd_phase_type           ph_prev;
   logic                    hit;
   logic                    fwd_raw;
   logic                    bad;
   logic                    fwd_sense;
   logic signed [CNT_W-1:0] position_next;

   // rising edge of one line between two samples
   function automatic logic rise_of(
      input logic now_lvl,
      input logic old_lvl
   );
      return now_lvl & ~old_lvl;
   endfunction

   // map the sampled pair {sign, pulse} onto a phase code
   function automatic pcd_phase_type phase_of(
      input logic [1:0] lines
   );
      pcd_phase_type ph;
      ph = PH_LL;
      unique case (lines)
         2'h0: ph = PH_LL;
         2'h1: ph = PH_HL;
         2'h3: ph = PH_HH;
         2'h2: ph = PH_LH;
      endcase
      return ph;
   endfunction

   // forward means the pulse line leads: LL, HL, HH, LH and round again
   function automatic logic quad_fwd(
      input pcd_phase_type from_ph,
      input pcd_phase_type to_ph
   );
      logic fwd;
      fwd = 1'b0;
      unique case (from_ph)
         PH_LL: fwd = (to_ph == PH_HL);
         PH_HL: fwd = (to_ph == PH_HH);
         PH_HH: fwd = (to_ph == PH_LH);
         PH_LH: fwd = (to_ph == PH_LL);
      endcase
      return fwd;
   endfunction

   // both lines moved in one sample: direction is unknowable, so no step
   function automatic logic quad_jump(
      input logic [1:0] now_lvl,
      input logic [1:0] old_lvl
   );
      return (now_lvl ^ old_lvl) == 2'h3;
   endfunction

   // next count for one step; wraps silently at the ends of the range
   function automatic logic signed [CNT_W-1:0] step_pos(
      input logic signed [CNT_W-1:0] pos,
      input logic                    fwd
   );
      return fwd ? pos + CNT_W'(1) : pos - CNT_W'(1);
   endfunction

   assign line_pin = {link.sign_line, link.pulse_line};

   // two flops per line; only the second one is read by the decoder
   for (genvar i = 0; i < LINES; i++) begin : gen_sync
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            s1_reg[i] <= 1'b0;
            s2_reg[i] <= 1'b0;
         end else begin
            s1_reg[i] <= line_pin[i];
            s2_reg[i] <= s1_reg[i];
         end
      end
   end

   // previous settled sample; resets to the idle level so no false edge follows
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prev_reg <= 2'h0;
      end else begin
         prev_reg <= s2_reg;
      end
   end

   assign ph_now  = phase_of(s2_reg);
   assign ph_prev = phase_of(prev_reg);

   // hit marks one counted step in this cycle, fwd_raw its sense before inversion
   always_comb begin
      hit     = 1'b0;
      fwd_raw = 1'b0;
      bad     = 1'b0;
      unique case (FORM)  // RL1
         FORM_PULSE_DIR: begin
            hit     = rise_of(s2_reg[0], prev_reg[0]);  // RL3
            fwd_raw = ~s2_reg[1];
         end
         FORM_FWD_REV: begin
            // rises on both trains in one cycle cancel instead of double counting
            hit     = rise_of(s2_reg[0], prev_reg[0]) ^ rise_of(s2_reg[1], prev_reg[1]);  // RL4
            fwd_raw = rise_of(s2_reg[0], prev_reg[0]);
         end
         default: begin
            bad     = quad_jump(s2_reg, prev_reg);  // RL10
            hit     = (ph_now != ph_prev) && !bad;  // RL5
            fwd_raw = quad_fwd(ph_prev, ph_now);  // RL10
         end
      endcase
   end

   assign fwd_sense = fwd_raw ^ INVERT;  // RL2

   always_comb begin
      position_next = position;
      if (hit) begin
         position_next = step_pos(position, fwd_sense);  // RL1
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         step_pulse <= 1'b0;
      end else begin
         step_pulse <= hit;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         step_fwd <= 1'b0;
      end else begin
         step_fwd <= fwd_sense;  // RL2
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bad_edge <= 1'b0;
      end else begin
         bad_edge <= bad;  // RL10
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         position <= '0;
      end else begin
         position <= position_next;
      end
   end

   // conducting means asserted, so reset leaves the output dark
   // the serial pair choice is a board jumper and has no logic here
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         out_opto_on <= 1'b0;
      end else begin
         out_opto_on <= out_cmd;  // RL9 RL8
      end
   end

endmodule
`default_nettype wire
